// file: hdl/cfei_pkg.sv
// Constants and carrier types of the CPU frame extract/inject block
package cfei_pkg;
    // Sizes
    localparam int NQ   = 8;
    localparam int NG   = 2;
    localparam int NP   = 12;
    localparam int NCLS = 12;
    localparam int NEN  = 14;
    localparam int NQS  = 13;
    localparam int CW   = 6;
    localparam logic [3:0] HOST_PORT = 4'hB;
    // Class and enable indices
    localparam int C_BPDU  = 0;
    localparam int C_ALLBR = 1;
    localparam int C_GARP  = 2;
    localparam int C_CCM   = 3;
    localparam int C_IGMP  = 4;
    localparam int C_MLD   = 5;
    localparam int C_IPMC  = 6;
    localparam int C_RGP   = 7;
    localparam int C_LRN   = 8;
    localparam int C_LOCK  = 9;
    localparam int C_LIMIT = 10;
    localparam int C_SRC   = 11;
    localparam int E_XHDR  = 12;
    localparam int E_IHDR  = 13;
    localparam int Q_MACC  = 12;
    // Register byte addresses
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_EXT   = 8'h04;
    localparam logic [7:0] A_REDIR = 8'h08;
    localparam logic [7:0] A_THR   = 8'h0C;
    localparam logic [7:0] A_XTR   = 8'h10;
    localparam logic [7:0] A_EN    = 8'h40;
    localparam logic [7:0] A_QSEL  = 8'h80;
    localparam logic [7:0] A_CNT   = 8'hC0;
    // Control field positions
    localparam int F_RR   = 8;
    localparam int F_DMA  = 10;
    localparam int F_RPB  = 12;
    localparam int F_RPX  = 13;
    localparam int F_RPI  = 14;
    localparam int F_PFX  = 15;
    localparam int F_EXTM = 8;
    // Reset values and frame constants
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [5:0]  THR_RST  = 6'h20;
    localparam logic [39:0] RSV_BASE = 40'h0180C20000;
    localparam logic [3:0]  NIB_BPDU = 4'h0;
    localparam logic [7:0]  ALLBR_LO = 8'h10;
    localparam logic [3:0]  NIB_GARP = 4'h2;
    localparam logic [3:0]  NIB_CCM  = 4'h3;

    typedef struct packed {
        logic v; logic [3:0] port; logic [47:0] dmac;
        logic igmp; logic mld; logic ipmc; logic rgp;
        logic lrn; logic lock; logic limit; logic macc;
        logic grp_cpu; logic grp_redir; logic [2:0] grp_q;
    } cfei_cls_in_t;
    typedef struct packed {
        logic v; logic [7:0] qmask; logic redir;
        logic ext; logic [3:0] ext_port;
    } cfei_cls_out_t;
    typedef struct packed {
        logic v; logic bypass; logic [11:0] dest;
    } cfei_inj_t;
    typedef struct packed {
        logic v; logic [3:0] src; logic bypass;
        logic [11:0] dest; logic grp;
    } cfei_core_inj_t;
    typedef struct packed {
        logic v; logic [3:0] port; logic bypass; logic [11:0] dest;
    } cfei_ing_t;
    typedef struct packed {
        logic v; logic parsed; logic bypass; logic [11:0] dest;
    } cfei_ing_out_t;
    typedef struct packed { logic v; logic [3:0] port; } cfei_port_ev_t;
    typedef struct packed {
        logic v; logic hdr; logic before_dmac; logic prefix;
    } cfei_hdr_t;
    typedef struct packed { logic v; logic [2:0] q; } cfei_pop_t;
endpackage

// file: hdl/cfei_top.sv
// CPU port: extraction queues, group schedulers, injection, headers
// Contract
// - CPU frames go to eight queues, each mapped to one of two groups
// - Each group has a strict or round robin scheduler over its queues
// - Two injection groups both feed the switch core
// - Every injected frame carries source port 11
// - Reserved range 0x frames copied or redirected per port to a queue
// - All-bridges address frames copied or redirected per port to a queue
// - Ranges 2x and 3x each have own port enable and queue
// - IGMP and MLD redirected, IP multicast control copied, own queues
// - Register protocol frames redirected per port to own queue
// - Learn, locked move and learn limit frames copied when enabled
// - Group entry or flood group with host bit sends to its queue
// - Source copy copies every frame of the port to its queue
// - Queues need shared pointers and obey the port 11 threshold
// - Frames leave through register reads or through the frame DMA
// - Register protocol engine can own one extract and one inject group
// - Extraction header inserted per port, before DMAC or after SMAC
// - Injection header interpreted when parsing enabled for the port
// - External host port number and queue mask are configurable
// - Per-port header insert and per-port header parse settings
// - External host header sits before DMAC with optional prefix
// - Injection header chooses analyzer or direct destination set
// - Multi-reason frame may reach internal queues and external host
//
// Added by the designer: the address map and the APB interface to the registers.
module cfei_top
    import cfei_pkg::*;
(
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           reset_n,
    // APB slave
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic                pready,
    output logic [31:0]         prdata,
    output logic                pslverr,
    // Analyzer classification
    input  wire cfei_cls_in_t   cls_in,
    input  wire logic           shared_free,
    output cfei_cls_out_t       cls_out,
    // Extraction pops
    input  wire logic [NG-1:0]  dma_pop,
    input  wire logic [NG-1:0]  rp_pop,
    output cfei_pop_t [NG-1:0]  pop_ans,
    // Injection
    input  wire cfei_inj_t [NG-1:0] inj_req,
    input  wire cfei_inj_t      rp_inj,
    input  wire logic           core_ready,
    output logic [NG-1:0]       inj_ack,
    output logic                rp_inj_ack,
    output cfei_core_inj_t      core_inj,
    // Port headers
    input  wire cfei_ing_t      ing_in,
    input  wire cfei_port_ev_t  eg_in,
    output cfei_ing_out_t       ing_out,
    output cfei_hdr_t           eg_out
);
    logic [15:0]   ctrl;
    logic [3:0]    ext_port;
    logic [7:0]    ext_mask;
    logic [3:0]    redir;
    logic [5:0]    thr;
    logic [NP-1:0] en [NEN];
    logic [2:0]    qsel [NQS];
    logic [CW-1:0] cnt [NQ];
    logic [2:0]    last [NG];
    logic [2:0]    apb_q;
    logic          apb_ok;
    logic          inj_turn;
    logic [31:0]   rd_val;
    logic          mapped;
    logic [7:0]    next_qmask;

    // APB decode
    wire apb_setup = psel & ~penable;
    wire apb_acc   = psel & penable & pready;
    wire apb_wr    = apb_acc & pwrite;
    wire [3:0] ridx = paddr[5:2];
    wire is_en  = paddr[7:6] == A_EN[7:6] && ridx < NEN;
    wire is_qs  = paddr[7:6] == A_QSEL[7:6] && ridx < NQS;
    wire is_cnt = paddr[7:5] == A_CNT[7:5] && !paddr[1];
    wire is_xtr = paddr[7:3] == A_XTR[7:3] && !paddr[1];
    wire xg     = paddr[2];

    // Classification helpers
    wire [3:0] sp   = cls_in.port;
    wire rsv        = cls_in.dmac[47:8] == RSV_BASE;
    wire [3:0] nib  = cls_in.dmac[7:4];
    logic [NCLS-1:0] match;
    logic [NCLS-1:0] hit;
    logic [2:0]      cq [NCLS];
    assign match[C_BPDU]  = rsv && nib == NIB_BPDU;
    assign match[C_ALLBR] = rsv && cls_in.dmac[7:0] == ALLBR_LO;
    assign match[C_GARP]  = rsv && nib == NIB_GARP;
    assign match[C_CCM]   = rsv && nib == NIB_CCM;
    assign match[C_IGMP]  = cls_in.igmp;
    assign match[C_MLD]   = cls_in.mld;
    assign match[C_IPMC]  = cls_in.ipmc;
    assign match[C_RGP]   = cls_in.rgp;
    assign match[C_LRN]   = cls_in.lrn;
    assign match[C_LOCK]  = cls_in.lock;
    assign match[C_LIMIT] = cls_in.limit;
    assign match[C_SRC]   = 1'b1;

    // Per-class port enable and queue; limit shares the learn queue
    for (genvar c = 0; c < NCLS; c++) begin : g_cls
        assign hit[c] = cls_in.v & match[c] & en[c][sp];
        assign cq[c]  = (c == C_LIMIT) ? qsel[C_LRN] : qsel[c];
    end

    // Queue mask of one frame, all reasons merged
    always_comb begin
        next_qmask = 8'h00;
        for (int c = 0; c < NCLS; c++) begin
            if (hit[c]) next_qmask[cq[c]] = 1'b1;
        end
        if (cls_in.v && cls_in.macc) next_qmask[qsel[Q_MACC]] = 1'b1;
        if (cls_in.v && cls_in.grp_cpu) next_qmask[cls_in.grp_q] = 1'b1;
    end

    // Redirect when any redirecting reason fires
    wire next_redir = hit[C_IGMP] | hit[C_MLD] | hit[C_RGP]
                    | |(hit[C_CCM:C_BPDU] & redir)
                    | (cls_in.v & cls_in.grp_cpu & cls_in.grp_redir);
    // split between internal queues and external host
    wire [7:0] int_mask = next_qmask & ~ext_mask;
    wire       to_ext   = |(next_qmask & ext_mask);

    // Scheduler pick: scan downward from start, first hit wins
    function automatic logic [3:0] pick(input logic [7:0] e,
                                        input logic [2:0] s);
        logic [3:0] r;
        logic [2:0] k;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            k = s - 3'(i);
            if (e[k]) r = {1'b1, k};
        end
        return r;
    endfunction

    logic [7:0]    nonempty;
    logic [7:0]    enq;
    logic [7:0]    deq;
    logic [7:0]    elig [NG];
    logic [3:0]    pk [NG];
    logic [2:0]    pq [NG];
    logic [NG-1:0] fire;
    logic [NG-1:0] ow_rp;
    logic [NG-1:0] ow_dma;

    for (genvar q = 0; q < NQ; q++) begin : g_q
        assign nonempty[q] = cnt[q] != '0;
        // shared pointers and port 11 threshold
        assign enq[q] = int_mask[q] & shared_free & (cnt[q] < thr);
        assign deq[q] = (fire[0] && pq[0] == 3'(q))
                      | (fire[1] && pq[1] == 3'(q));
    end

    for (genvar g = 0; g < NG; g++) begin : g_grp
        assign elig[g] = nonempty & (g == 0 ? ~ctrl[7:0] : ctrl[7:0]);
        // strict or round robin per group
        // strict starts from the top queue
        assign pk[g] = pick(elig[g], ctrl[F_RR + g] ? last[g] - 3'h1
                                                      : 3'h7);
        // engine may own one extraction group
        assign ow_rp[g]  = ctrl[F_RPB] && ctrl[F_RPX] == 1'(g);
        assign ow_dma[g] = ~ow_rp[g] & ctrl[F_DMA + g];
        // register, DMA or engine drains the group
        assign fire[g] = ow_rp[g]  ? pk[g][3] & rp_pop[g]
                       : ow_dma[g] ? pk[g][3] & dma_pop[g]
                       : apb_acc & ~pwrite & is_xtr & xg == 1'(g)
                         & apb_ok;
        assign pq[g] = (ow_rp[g] | ow_dma[g]) ? pk[g][2:0] : apb_q;
    end

    // Register read mux
    always_comb begin
        rd_val = 32'h0;
        mapped = 1'b1;
        if (paddr == A_CTRL) begin
            rd_val = 32'(ctrl);
        end else if (paddr == A_EXT) begin
            rd_val = {16'h0, ext_mask, 4'h0, ext_port};
        end else if (paddr == A_REDIR) begin
            rd_val = 32'(redir);
        end else if (paddr == A_THR) begin
            rd_val = 32'(thr);
        end else if (is_xtr) begin
            rd_val = (ow_rp[xg] | ow_dma[xg]) ? 32'h0 : 32'(pk[xg]);
        end else if (is_en) begin
            rd_val = 32'(en[ridx]);
        end else if (is_qs) begin
            rd_val = 32'(qsel[ridx]);
        end else if (is_cnt) begin
            rd_val = 32'(cnt[paddr[4:2]]);
        end else begin
            mapped = 1'b0;
        end
    end

    // APB answer one cycle after setup; pop choice frozen at setup
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
            apb_q   <= 3'h0;
            apb_ok  <= 1'b0;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~mapped;
            if (apb_setup) begin
                prdata <= pwrite ? 32'h0 : rd_val;
                apb_q  <= pk[xg][2:0];
                apb_ok <= is_xtr & pk[xg][3] & ~ow_rp[xg] & ~ow_dma[xg];
            end
        end
    end

    // Configuration writes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl     <= CTRL_RST;
            ext_port <= 4'h0;
            ext_mask <= 8'h00;
            redir    <= 4'h0;
            thr      <= THR_RST;
            for (int i = 0; i < NEN; i++) en[i] <= '0;
            for (int i = 0; i < NQS; i++) qsel[i] <= 3'h0;
        end else if (apb_wr) begin
            if (paddr == A_CTRL) begin
                ctrl <= pwdata[15:0];
            end else if (paddr == A_EXT) begin
                // external host port and queue mask
                ext_port <= pwdata[3:0];
                ext_mask <= pwdata[F_EXTM +: 8];
            end else if (paddr == A_REDIR) begin
                redir <= pwdata[3:0];
            end else if (paddr == A_THR) begin
                thr <= pwdata[5:0];
            end else if (is_en) begin
                en[ridx] <= pwdata[NP-1:0];
            end else if (is_qs) begin
                qsel[ridx] <= pwdata[2:0];
            end
        end
    end

    // Queue occupancy and round robin pointers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int q = 0; q < NQ; q++) cnt[q] <= '0;
            for (int g = 0; g < NG; g++) last[g] <= 3'h0;
        end else begin
            for (int q = 0; q < NQ; q++) begin
                cnt[q] <= cnt[q] + CW'(enq[q]) - CW'(deq[q]);
            end
            for (int g = 0; g < NG; g++) begin
                if (fire[g]) last[g] <= pq[g];
            end
        end
    end

    // Classification result and pop answers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cls_out <= '0;
            pop_ans <= '0;
        end else begin
            cls_out <= {cls_in.v, next_qmask, next_redir, to_ext,
                        ext_port};
            for (int g = 0; g < NG; g++) begin
                pop_ans[g] <= {fire[g] & (ow_rp[g] | ow_dma[g]), pq[g]};
            end
        end
    end

    // Injection sources; the engine may take over one group
    cfei_inj_t src [NG];
    logic [NG-1:0] ielig;
    wire slot_free = ~core_inj.v | core_ready;
    for (genvar g = 0; g < NG; g++) begin : g_inj
        // engine replies through its injection group
        wire rp_here = ctrl[F_RPB] && ctrl[F_RPI] == 1'(g);
        assign src[g]   = rp_here ? rp_inj : inj_req[g];
        assign ielig[g] = src[g].v
                        & ~(rp_here ? rp_inj_ack : inj_ack[g]);
    end
    wire ig = (ielig == 2'b11) ? inj_turn : ielig[1];
    wire take = slot_free & |ielig;

    // Injection into the core, held until the core takes it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            core_inj   <= '0;
            inj_ack    <= '0;
            rp_inj_ack <= 1'b0;
            inj_turn   <= 1'b0;
        end else begin
            inj_ack    <= '0;
            rp_inj_ack <= 1'b0;
            if (take) begin
                core_inj.v      <= 1'b1;
                core_inj.src    <= HOST_PORT;
                core_inj.bypass <= src[ig].bypass;
                core_inj.dest   <= src[ig].bypass ? src[ig].dest
                                                  : 12'h000;
                core_inj.grp    <= ig;
                inj_turn        <= ~ig;
                if (ctrl[F_RPB] && ctrl[F_RPI] == ig) begin
                    rp_inj_ack <= 1'b1;
                end else begin
                    inj_ack[ig] <= 1'b1;
                end
            end else if (core_ready) begin
                core_inj.v <= 1'b0;
            end
        end
    end

    // Port header handling
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ing_out <= '0;
            eg_out  <= '0;
        end else begin
            // header interpreted only when parsing is on
            ing_out.v      <= ing_in.v;
            ing_out.parsed <= en[E_IHDR][ing_in.port];
            ing_out.bypass <= en[E_IHDR][ing_in.port] & ing_in.bypass;
            ing_out.dest   <= en[E_IHDR][ing_in.port] ? ing_in.dest
                                                      : 12'h000;
            // header insert, placement by port role
            // external host gets header before DMAC
            eg_out.v           <= eg_in.v;
            eg_out.hdr         <= en[E_XHDR][eg_in.port];
            eg_out.before_dmac <= eg_in.port == ext_port;
            eg_out.prefix      <= ctrl[F_PFX] & (eg_in.port == ext_port);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_src_port: assert property (
        take |=> core_inj.v && core_inj.src == 4'hB)
        else $error("injected frame lacks host source port");
    chk_ack_grp: assert property (
        inj_ack[1] |-> core_inj.v && core_inj.grp == 1'b1)
        else $error("ack does not match injected group");
    chk_no_ptr: assert property (
        !shared_free |-> enq == 8'h00)
        else $error("enqueue without shared pointers");
    chk_strict_top: assert property (
        !ctrl[F_RR] && pk[0][3] |-> (elig[0] >> pk[0][2:0]) == 8'h01)
        else $error("strict pick is not the top queue");
    chk_ext_split: assert property (
        cls_in.v |=> cls_out.ext == |(cls_out.qmask & $past(ext_mask)))
        else $error("external host flag wrong");
    chk_bpdu_queue: assert property (
        hit[C_BPDU] |=> cls_out.qmask[$past(qsel[C_BPDU])])
        else $error("reserved range frame missed its queue");
    chk_igmp_redir: assert property (
        hit[C_IGMP] |=> cls_out.redir)
        else $error("IGMP frame not redirected");
    chk_pop_dma: assert property (
        ow_dma[0] && dma_pop[0] && pk[0][3] |=> pop_ans[0].v
        ##1 !pop_ans[0].v || $past(fire[0]))
        else $error("DMA pop not answered");
    chk_eg_hdr: assert property (
        eg_in.v && en[E_XHDR][eg_in.port] |=> eg_out.v && eg_out.hdr)
        else $error("egress header insert missed");
    chk_apb_ready: assert property (
        apb_setup |=> pready ##1 !pready)
        else $error("APB answer timing wrong");

    cov_ext_both: cover property (cls_out.v && cls_out.ext
                                  && |(cls_out.qmask & ~ext_mask));
    cov_bypass: cover property (core_inj.v && core_inj.bypass);
    cov_rr_pop: cover property (ctrl[F_RR] && fire[0]);
endmodule

// file: test/cfei_core_model.sv
// Switch core model that accepts injected frames, promptly or slowly
module cfei_core_model
    import cfei_pkg::*;
(
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           reset_n,
    // Injection from the CPU port
    input  wire cfei_core_inj_t core_inj,
    input  wire logic [3:0]     stall,
    output logic                core_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] wait_cnt;

    // Ready only after stall cycles, so a held request is really held
    assign core_ready = core_inj.v && (wait_cnt >= stall);

    // Wait counter restarts on every accept or idle cycle
    always_ff @(posedge clk) begin
        if (!reset_n || !core_inj.v || core_ready) begin
            wait_cnt <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

// file: test/tb_top.sv
// Self-checking bench for the CPU frame extract/inject block
module tb_top
    import cfei_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  clk = 1'b0;
    logic                  reset_n = 1'b0;
    logic                  psel, penable, pwrite, pready, pslverr;
    logic [7:0]            paddr;
    logic [31:0]           pwdata, prdata, rd;
    logic                  er, shared_free, rp_inj_ack, core_ready;
    logic [3:0]            stall;
    logic [NG-1:0]         dma_pop, rp_pop, inj_ack;
    cfei_cls_in_t          cls_in, c;
    cfei_cls_out_t         cls_out;
    cfei_pop_t [NG-1:0]    pop_ans;
    cfei_inj_t [NG-1:0]    inj_req;
    cfei_inj_t             rp_inj;
    cfei_core_inj_t        core_inj;
    cfei_ing_t             ing_in;
    cfei_ing_out_t         ing_out;
    cfei_port_ev_t         eg_in;
    cfei_hdr_t             eg_out;
    int                    n_mismatch = 0, checked = 0, cyc = 0, k, n;
    // Low byte of each reserved address class; expected redirect per class
    logic [7:0]            sfx [4] = '{8'h05, 8'h10, 8'h21, 8'h3F};
    logic [7:0]            rdx = 8'hB5;

    // Block under test; the bench also plays the register-protocol engine
    cfei_top dut (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .cls_in(cls_in), .shared_free(shared_free), .cls_out(cls_out),
        .dma_pop(dma_pop), .rp_pop(rp_pop), .pop_ans(pop_ans),
        .inj_req(inj_req), .rp_inj(rp_inj), .core_ready(core_ready),
        .inj_ack(inj_ack), .rp_inj_ack(rp_inj_ack), .core_inj(core_inj),
        .ing_in(ing_in), .eg_in(eg_in), .ing_out(ing_out), .eg_out(eg_out));

    cfei_core_model core (.clk(clk), .reset_n(reset_n), .core_inj(core_inj),
        .stall(stall), .core_ready(core_ready));

    // 250 MHz clock
    always #2 clk = ~clk;

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // APB master: setup, then access held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        chk(32'(pready), 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // Requests launched one edge, dropped the next, answer sampled after
    task go();
        @(posedge clk);
        cls_in.v <= 1'b0;
        dma_pop <= '0;
        rp_pop <= '0;
        ing_in.v <= 1'b0;
        eg_in.v <= 1'b0;
        @(posedge clk);
    endtask

    task cls_send(input int i, input logic [3:0] p);
        c = '0;
        c.v = 1'b1;
        c.port = p;
        c.dmac = (i < 4) ? {RSV_BASE, sfx[i[1:0]]} : 48'h0200_0000_0001;
        c.igmp = (i == 4);
        c.mld = (i == 5);
        c.ipmc = (i == 6);
        c.rgp = (i == 7);
        cls_in <= c;
        go();
    endtask

    task pop(input int g);
        dma_pop[g] <= 1'b1;
        go();
    endtask

    task wrap_up();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {cls_in, dma_pop, rp_pop, inj_req, rp_inj, ing_in, eg_in} = '0;
        shared_free = 1'b1;
        stall = 4'h2;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rchk(A_CTRL, 32'h0);
        rchk(A_THR, 32'h20);
        rchk(8'hFC, 32'h0);
        chk(32'(er), 32'h1);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, A_EN + 8'(4 * i), 32'h008);
            apb(1'b1, A_QSEL + 8'(4 * i), 32'(i));
        end
        apb(1'b1, A_REDIR, 32'h5);
        for (int i = 0; i < 8; i++) begin
            cls_send(i, 4'h3);
            chk(32'({cls_out.v, cls_out.redir, cls_out.qmask}),
                32'({1'b1, rdx[i], 8'(1 << i)}));
        end
        cls_send(0, 4'h4);
        chk(32'({cls_out.v, cls_out.qmask}), 32'h100);
        for (int q = 0; q < 8; q++) rchk(A_CNT + 8'(4 * q), 32'h1);
        shared_free <= 1'b0;
        cls_send(0, 4'h3);
        shared_free <= 1'b1;
        rchk(A_CNT, 32'h1);
        apb(1'b1, A_THR, 32'h1);
        cls_send(0, 4'h3);
        rchk(A_CNT, 32'h1);
        $display("test classification done");
        apb(1'b1, A_CTRL, 32'h0480);
        pop(0);
        chk(32'({pop_ans[0].v, pop_ans[0].q}), 32'hE);
        pop(0);
        chk(32'({pop_ans[0].v, pop_ans[0].q}), 32'hD);
        rchk(A_XTR + 8'h4, 32'hF);
        apb(1'b0, A_XTR + 8'h4, 32'h0);
        chk(rd & 32'h8, 32'h0);
        pop(1);
        chk(32'(pop_ans[1].v), 32'h0);
        rchk(A_CNT + 8'h18, 32'h0);
        // Round robin: queue 4 holds two frames, strict would repeat it
        apb(1'b1, A_THR, 32'h20);
        cls_send(4, 4'h3);
        apb(1'b1, A_CTRL, 32'h0580);
        pop(0);
        chk(32'({pop_ans[0].v, pop_ans[0].q}), 32'hC);
        pop(0);
        chk(32'({pop_ans[0].v, pop_ans[0].q}), 32'hB);
        $display("test extraction done");
        inj_req[0] <= cfei_inj_t'{1'b1, 1'b1, 12'h0A5};
        inj_req[1] <= cfei_inj_t'{1'b1, 1'b0, 12'h3FF};
        k = 0;
        n = 0;
        while (k < 2 && n < 60) begin
            @(posedge clk);
            n++;
            if (inj_ack[0] === 1'b1) inj_req[0].v <= 1'b0;
            if (inj_ack[1] === 1'b1) inj_req[1].v <= 1'b0;
            if (core_ready === 1'b1 && core_inj.v === 1'b1) begin
                chk(32'({core_inj.src, core_inj.grp, core_inj.bypass,
                    core_inj.dest}), (k == 0) ?
                    32'({HOST_PORT, 1'b0, 1'b1, 12'h0A5}) :
                    32'({HOST_PORT, 1'b1, 1'b0, 12'h000}));
                k++;
            end
        end
        chk(32'(k), 32'h2);
        // Engine owns extract group 1 and inject group 0
        apb(1'b1, A_CTRL, 32'h3080);
        cls_send(7, 4'h3);
        rp_pop[1] <= 1'b1;
        go();
        chk(32'({pop_ans[1].v, pop_ans[1].q}), 32'hF);
        rp_inj <= cfei_inj_t'{1'b1, 1'b1, 12'h055};
        do begin
            @(posedge clk);
        end while (rp_inj_ack !== 1'b1);
        rp_inj.v <= 1'b0;
        chk(32'({core_inj.src, core_inj.grp, core_inj.dest}),
            32'({HOST_PORT, 1'b0, 12'h055}));
        $display("test injection done");
        apb(1'b1, A_EXT, 32'h0109);
        rchk(A_EXT, 32'h0109);
        apb(1'b1, A_EN + 8'h30, 32'h208);
        apb(1'b1, A_EN + 8'h34, 32'h004);
        apb(1'b1, A_CTRL, 32'h8480);
        cls_send(0, 4'h3);
        chk(32'({cls_out.ext, cls_out.ext_port, cls_out.qmask}),
            32'h1901);
        eg_in <= cfei_port_ev_t'{1'b1, 4'h9};
        go();
        chk(32'(eg_out), 32'hF);
        eg_in <= cfei_port_ev_t'{1'b1, 4'h3};
        go();
        chk(32'({eg_out.v, eg_out.hdr, eg_out.before_dmac}), 32'h6);
        eg_in <= cfei_port_ev_t'{1'b1, 4'h4};
        go();
        chk(32'({eg_out.v, eg_out.hdr}), 32'h2);
        ing_in <= cfei_ing_t'{1'b1, 4'h2, 1'b1, 12'h123};
        go();
        chk(32'(ing_out), 32'h7123);
        ing_in <= cfei_ing_t'{1'b1, 4'h4, 1'b1, 12'h123};
        go();
        chk(32'({ing_out.v, ing_out.parsed}), 32'h2);
        $display("test headers done");
        wrap_up();
    end
endmodule
